// [inc/occ_cfg.svh]
// register offsets, field positions and reset values of the compare channel
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH
// ****************************************************************
// register byte addresses
// ****************************************************************
`define OCC_ADDR_CON1    12'h000
`define OCC_ADDR_CON2    12'h004
`define OCC_ADDR_PRI     12'h008
`define OCC_ADDR_SEC     12'h00C
`define OCC_ADDR_TMR     12'h010
`define OCC_ADDR_PERIOD  12'h014
// ****************************************************************
// field positions
// ****************************************************************
`define OCC_MODE_LSB     0
`define OCC_MODE_MSB     2
`define OCC_TRIGGER_STATUS_CLEAR_MODE_BIT 3
`define OCC_CLKSEL_LSB   10
`define OCC_CLKSEL_MSB   12
`define OCC_TSTAT_BIT    6
`define OCC_OUT_BIT      7
`define OCC_CON1_MASK    16'h1C0F
// ****************************************************************
// reset values and clock choices
// ****************************************************************
`define OCC_RST16        16'h0000
`define OCC_RST_PERIOD   16'hFFFF
`define OCC_CLK_SYS      3'h7
`define OCC_CLK_TRG      3'h5
`define OCC_ERR_NONE     1'h0
`endif

// [inc/occ_pkg.sv]
// types shared by the compare channel files
package occ_pkg;
  typedef enum logic [2:0]
  {
    OCC_OFF     = 3'b000,
    OCC_SS_HIGH = 3'b001,
    OCC_SS_LOW  = 3'b010,
    OCC_TOGGLE  = 3'b011,
    OCC_DBL_SS  = 3'b100,
    OCC_DBL_CON = 3'b101,
    OCC_PWM_EDG = 3'b110,
    OCC_PWM_CTR = 3'b111
  } occ_mode_type;
endpackage

// [logic/occ_sync.sv]
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module occ_sync
(
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  // first stage feeds only the second
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [logic/occ_channel.sv]
// output compare channel with its apb register file
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "occ_cfg.svh"
// Functional notes
// - trigger mode one: flag clears on timer equal secondary, or by software.
// - trigger mode zero: only software clears the flag.
// - mode 111: output high on primary match, low on secondary match.
// - mode 110: output high at timer zero, low on primary match.
// - mode 101: start low, toggle on alternate primary and secondary matches.
// - mode 100: start low, toggle on primary then secondary, one pulse.
// - mode 011: toggle output on every primary match.
// - mode 010: start high, go low on primary match and stay.
// - mode 001: start low, go high on primary match and stay.
// - mode 000: channel disabled, no compare actions.
// - compare values double-buffered in pwm modes only, else direct.
// - one dedicated trigger generator clock per channel, index parameter.
module occ_channel
#(
  parameter int CHANNEL = 1
)
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [3:0]  TRG_CLK_IN,
  input  wire logic        TRIGGER_IN,
  output logic             COMPARE_OUTPUT
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] con1_r;
  logic [15:0] pri_buf_r;
  logic [15:0] sec_buf_r;
  logic [15:0] pri_act_r;
  logic [15:0] sec_act_r;
  logic [15:0] period_r;
  logic [15:0] timer_r;
  logic        tstat_r;
  logic        out_r;
  logic        alt_r;
  logic        done_r;
  logic        trg_q;
  logic        trg_d_r;
  logic        trig_q;
  occ_pkg::occ_mode_type mode;
  occ_pkg::occ_mode_type mode_d_r;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        pri_hit;
  logic        sec_hit;
  logic        wrap;
  logic [15:0] timer_nxt;
  logic [15:0] rdata;

  // true for the two pwm modes
  function automatic logic is_pwm(input occ_pkg::occ_mode_type m);
    is_pwm = (m == occ_pkg::OCC_PWM_EDG) || (m == occ_pkg::OCC_PWM_CTR);
  endfunction

  // register address match
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // decoded mode and bus strobes: a write lands on the ready edge only
  assign mode = occ_pkg::occ_mode_type'(con1_r[`OCC_MODE_MSB:`OCC_MODE_LSB]);
  assign wr   = PSEL && PENABLE && PWRITE && PREADY && CE;
  assign rd   = PSEL && !PENABLE && !PWRITE && CE;

  // ****************************************************************
  // timer clock selection
  // ****************************************************************
  // the channel's own generator output passes two flip-flops first
  occ_sync u_trg_sync
  (
    .CLK (CLK),
    .RST (RST),
    .d   (TRG_CLK_IN[CHANNEL-1]),
    .q   (trg_q)
  );

  // trigger input, used to synchronise the timer
  occ_sync u_trig_sync
  (
    .CLK (CLK),
    .RST (RST),
    .d   (TRIGGER_IN),
    .q   (trig_q)
  );

  // edge detect on the synchronised generator clock
  // resets to the idle low level, so no false tick follows reset
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      trg_d_r <= 1'b0;
    else if (CE)
      trg_d_r <= trg_q;
  end

  // timer advances every cycle or on generator rising edge
  always_comb
  begin
    case (con1_r[`OCC_CLKSEL_MSB:`OCC_CLKSEL_LSB])
      `OCC_CLK_SYS: tick = 1'b1;
      `OCC_CLK_TRG: tick = trg_q && !trg_d_r;
      default:      tick = 1'b1;
    endcase
  end

  // wrap, next count and matches; a match only counts on a timer tick
  assign wrap      = (timer_r == period_r);
  assign timer_nxt = wrap ? `OCC_RST16 : timer_r + 16'h0001;
  assign pri_hit   = tick && (timer_r == pri_act_r);
  assign sec_hit   = tick && (timer_r == sec_act_r);

  // ****************************************************************
  // channel timer
  // ****************************************************************
  // free running, cleared by the trigger or when disabled
  // a trigger outranks a software timer write in the same cycle
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      timer_r <= `OCC_RST16;
    else if (CE)
    begin
      if (mode == occ_pkg::OCC_OFF || trig_q)
        timer_r <= `OCC_RST16;
      else if (wr && hit(PADDR, `OCC_ADDR_TMR))
        timer_r <= PWDATA[15:0];
      else if (tick)
        timer_r <= timer_nxt;
    end
  end

  // ****************************************************************
  // apb registers
  // ****************************************************************
  // control word and timer period
  // reserved control bits are masked so they always read as zero
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      con1_r   <= `OCC_RST16;
      period_r <= `OCC_RST_PERIOD;
    end
    else if (CE && wr)
    begin
      if (hit(PADDR, `OCC_ADDR_CON1))
        con1_r <= PWDATA[15:0] & `OCC_CON1_MASK;
      if (hit(PADDR, `OCC_ADDR_PERIOD))
        period_r <= PWDATA[15:0];
    end
  end

  // software-side compare values
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pri_buf_r <= `OCC_RST16;
      sec_buf_r <= `OCC_RST16;
    end
    else if (CE && wr)
    begin
      if (hit(PADDR, `OCC_ADDR_PRI))
        pri_buf_r <= PWDATA[15:0];
      if (hit(PADDR, `OCC_ADDR_SEC))
        sec_buf_r <= PWDATA[15:0];
    end
  end

  // active compares: direct outside pwm, loaded at period start in pwm
  // outside pwm a buffer write reaches the comparator one cycle later
  // in pwm the swap waits for the wrap so no period is cut short
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pri_act_r <= `OCC_RST16;
      sec_act_r <= `OCC_RST16;
    end
    else if (CE)
    begin
      if (!is_pwm(mode))
      begin
        pri_act_r <= pri_buf_r;
        sec_act_r <= sec_buf_r;
      end
      else if (tick && wrap)
      begin
        pri_act_r <= pri_buf_r;
        sec_act_r <= sec_buf_r;
      end
    end
  end

  // ****************************************************************
  // trigger status flag
  // ****************************************************************
  // trigger sets; a set in the clear cycle wins
  // software clears by writing zero to the flag bit
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      tstat_r <= 1'b0;
    else if (CE)
    begin
      if (trig_q)
        tstat_r <= 1'b1;
      else if (wr && hit(PADDR, `OCC_ADDR_CON2) && !PWDATA[`OCC_TSTAT_BIT])
        tstat_r <= 1'b0;
      else if (con1_r[`OCC_TRIGGER_STATUS_CLEAR_MODE_BIT] && sec_hit)
        tstat_r <= 1'b0;
    end
  end

  // ****************************************************************
  // compare output
  // ****************************************************************
  // mode change initialises the pin, then matches act on it
  // toggle mode keeps its level so a mode rewrite causes no glitch
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      mode_d_r <= occ_pkg::OCC_OFF;
      out_r    <= 1'b0;
      alt_r    <= 1'b0;
      done_r   <= 1'b0;
    end
    else if (CE)
    begin
      mode_d_r <= mode;
      if (mode != mode_d_r)
      begin
        alt_r  <= 1'b0;
        done_r <= 1'b0;
        case (mode)
          occ_pkg::OCC_SS_LOW: out_r <= 1'b1;
          occ_pkg::OCC_TOGGLE: out_r <= out_r;
          default:             out_r <= 1'b0;
        endcase
      end
      else
      begin
        case (mode)
          occ_pkg::OCC_OFF: out_r <= out_r;
          occ_pkg::OCC_SS_HIGH:
            if (pri_hit) out_r <= 1'b1;
          occ_pkg::OCC_SS_LOW:
            if (pri_hit) out_r <= 1'b0;
          occ_pkg::OCC_TOGGLE:
            if (pri_hit) out_r <= !out_r;
          occ_pkg::OCC_DBL_SS:
            if (!done_r && !alt_r && pri_hit)
            begin
              out_r <= 1'b1;
              alt_r <= 1'b1;
            end
            else if (!done_r && alt_r && sec_hit)
            begin
              out_r  <= 1'b0;
              done_r <= 1'b1;
            end
          occ_pkg::OCC_DBL_CON:
            if ((!alt_r && pri_hit) || (alt_r && sec_hit))
            begin
              out_r <= !out_r;
              alt_r <= !alt_r;
            end
          occ_pkg::OCC_PWM_EDG:
            if (pri_hit) out_r <= 1'b0;
            else if (tick && timer_r == `OCC_RST16) out_r <= 1'b1;
          occ_pkg::OCC_PWM_CTR:
            if (pri_hit) out_r <= 1'b1;
            else if (sec_hit) out_r <= 1'b0;
          default: out_r <= out_r;
        endcase
      end
    end
  end

  // pin follows the register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      COMPARE_OUTPUT <= 1'b0;
    else if (CE)
      COMPARE_OUTPUT <= out_r;
  end

  // ****************************************************************
  // apb read path
  // ****************************************************************
  // read mux
  always_comb
  begin
    case (PADDR)
      `OCC_ADDR_CON1:   rdata = con1_r;
      `OCC_ADDR_CON2:   rdata = {8'h00, out_r, tstat_r, 6'h00};
      `OCC_ADDR_PRI:    rdata = pri_buf_r;
      `OCC_ADDR_SEC:    rdata = sec_buf_r;
      `OCC_ADDR_TMR:    rdata = timer_r;
      `OCC_ADDR_PERIOD: rdata = period_r;
      default:          rdata = `OCC_RST16;
    endcase
  end

  // data captured in setup, ready one cycle later
  // zero wait states: ready is high in the access cycle only
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= `OCC_ERR_NONE;
    end
    else if (CE)
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= `OCC_ERR_NONE;
      if (rd)
        PRDATA <= {16'h0000, rdata};
    end
  end
endmodule

// [tb/occ_load.sv]
// pin load model that tallies high cycles and level changes
`timescale 1ns/1ps
module occ_load
(
  input wire logic clk,
  input wire logic pin,
  output int       hi_cnt,
  output int       edge_cnt
);
  logic last_r;
  // counters start clear before any clock edge
  initial
  begin
    hi_cnt = 0;
    edge_cnt = 0;
    last_r = 1'b0;
  end
  // tally the pin level once per clock
  always @(posedge clk)
  begin
    hi_cnt <= hi_cnt + int'(pin === 1'b1);
    if (pin !== last_r)
      edge_cnt <= edge_cnt + 1;
    last_r <= pin;
  end
endmodule

// [tb/occ_channel_sva.sv]
// port checker for the compare channel
`timescale 1ns/1ps
`include "occ_cfg.svh"
module occ_channel_sva
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        COMPARE_OUTPUT
);
  logic [2:0] md_r;
  logic [2:0] age_r;
  wire        wr_con;
  // ****************
  // mode shadow
  // ****************
  assign wr_con = PREADY && PWRITE && PADDR == `OCC_ADDR_CON1;
  // latch the mode written and count cycles since
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      md_r <= 3'h0;
    else if (wr_con)
      md_r <= PWDATA[2:0];
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      age_r <= 3'h0;
    else if (wr_con)
      age_r <= 3'h0;
    else if (age_r != 3'h7)
      age_r <= age_r + 3'h1;
  // ****************
  // properties
  // ****************
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence settled(m);
    md_r == m && age_r > 3'h3;
  endsequence
  setup_ready_a: assert property (PSEL && !PENABLE && CE |=> PREADY)
    else $error("no ready after setup");
  ready_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  no_slverr_a: assert property (!PSLVERR)
    else $error("error response");
  read_upper_a: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0)
    else $error("upper read bits set");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  reset_quiet_a: assert property ($fell(RST) |-> !PREADY && !COMPARE_OUTPUT)
    else $error("outputs busy after reset");
  off_still_a: assert property (
      settled(3'h0) |-> $stable(COMPARE_OUTPUT))
    else $error("pin moved while disabled");
  high_hold_a: assert property (
      settled(3'h1) ##0 COMPARE_OUTPUT |=> COMPARE_OUTPUT)
    else $error("pin left high");
  low_hold_a: assert property (
      settled(3'h2) ##0 !COMPARE_OUTPUT |=> !COMPARE_OUTPUT)
    else $error("pin left low");
  pulse_once_a: assert property (
      settled(3'h4) ##0 $fell(COMPARE_OUTPUT) |=> !COMPARE_OUTPUT [*8])
    else $error("second pulse");
endmodule
bind occ_channel occ_channel_sva u_sva
(
  .CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .COMPARE_OUTPUT(COMPARE_OUTPUT)
);

// [tb/output_compare_mode_logic_test.sv]
// self-checking bench of the compare channel
`timescale 1ns/1ps
`include "occ_cfg.svh"
module output_compare_mode_logic_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [3:0]  trg = 4'h0;
  logic        trig = 1'b0;
  logic [31:0] prd;
  logic        prdy;
  logic        cout;
  int          hi_cnt;
  int          edge_cnt;
  int          error_cnt = 0;
  int          checked = 0;
  // ****************
  // clock, design and load
  // ****************
  always #50 clk = ~clk;
  occ_channel #(.CHANNEL(1)) DUT
  (
    .CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(), .TRG_CLK_IN(trg), .TRIGGER_IN(trig),
    .COMPARE_OUTPUT(cout)
  );
  occ_load u_load
  (
    .clk(clk), .pin(cout), .hi_cnt(hi_cnt), .edge_cnt(edge_cnt)
  );
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // one apb transfer, held until ready is sampled
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    chk(prdy, 1'b1);
    q = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    rd(`OCC_ADDR_CON1, 32'hFFFF, 32'h0);
    rd(`OCC_ADDR_PERIOD, 32'hFFFF, 32'hFFFF);
    wr(12'h020, 32'h5A);
    rd(12'h020, 32'hFFFFFFFF, 32'h0);
    wr(`OCC_ADDR_PERIOD, 32'hF);
    wr(`OCC_ADDR_PRI, 32'h4);
    wr(`OCC_ADDR_SEC, 32'hC);
    $display("regs done");
  endtask
  // start a mode from timer zero, then tally the pin
  task automatic run(input logic [2:0] m, input int hi, input int ed);
    int h;
    int e;
    // generator clock holds the timer still while it is set up
    wr(`OCC_ADDR_CON1, {16'h0, 3'h0, `OCC_CLK_TRG, 7'h0, m});
    wr(`OCC_ADDR_TMR, 32'h0);
    e = edge_cnt;
    wr(`OCC_ADDR_CON1, {16'h0, 3'h0, `OCC_CLK_SYS, 7'h0, m});
    repeat (32) @(posedge clk);
    h = hi_cnt;
    repeat (64) @(posedge clk);
    if (hi >= 0)
      chk(hi_cnt - h, hi);
    if (ed >= 0)
      chk(edge_cnt - e, ed);
    $display("mode %0d done", m);
  endtask
  // new duty value lands at the next period
  task automatic t_buf;
    int h;
    wr(`OCC_ADDR_CON1, {16'h0, 3'h0, `OCC_CLK_TRG, 7'h0, 3'h6});
    wr(`OCC_ADDR_TMR, 32'h0);
    wr(`OCC_ADDR_PRI, 32'h8);
    wr(`OCC_ADDR_CON1, {16'h0, 3'h0, `OCC_CLK_SYS, 7'h0, 3'h6});
    repeat (2) @(posedge clk);
    h = hi_cnt;
    repeat (16) @(posedge clk);
    chk(hi_cnt - h, 4);
    h = hi_cnt;
    repeat (64) @(posedge clk);
    chk(hi_cnt - h, 32);
    $display("buffer done");
  endtask
  task automatic t_trig(input logic tm, input logic e);
    wr(`OCC_ADDR_CON1, {16'h0, 3'h0, `OCC_CLK_SYS, 6'h0, tm, 3'h3});
    trig <= 1'b1;
    repeat (3) @(posedge clk);
    trig <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`OCC_ADDR_CON2, 32'h40, 32'h40);
    repeat (40) @(posedge clk);
    rd(`OCC_ADDR_CON2, 32'h40, {25'h0, e, 6'h0});
    wr(`OCC_ADDR_CON2, 32'h0);
    rd(`OCC_ADDR_CON2, 32'h40, 32'h0);
    $display("trigger done");
  endtask
  // only this channel's generator clock moves the timer
  task automatic t_trg;
    wr(`OCC_ADDR_CON1, {16'h0, 3'h0, `OCC_CLK_TRG, 7'h0, 3'h3});
    wr(`OCC_ADDR_TMR, 32'h0);
    repeat (20) @(posedge clk) trg <= trg ^ 4'hE;
    repeat (4) @(posedge clk);
    rd(`OCC_ADDR_TMR, 32'hFFFF, 32'h0);
    repeat (20) @(posedge clk) trg <= trg ^ 4'h1;
    repeat (4) @(posedge clk);
    rd(`OCC_ADDR_TMR, 32'hFFFF, 32'hA);
    $display("clock source done");
  endtask
  task automatic final_report;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ****************
  // main sequence and watchdog
  // ****************
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    run(3'h1, 64, 1);
    run(3'h2, 0, 1);
    run(3'h3, 32, 6);
    run(3'h4, 0, 2);
    run(3'h5, 32, -1);
    run(3'h7, 32, -1);
    run(3'h0, -1, 0);
    run(3'h6, 16, -1);
    t_buf;
    t_trig(1'b0, 1'b1);
    t_trig(1'b1, 1'b0);
    t_trg;
    final_report;
  end
  initial
  begin
    #2000000;
    error_cnt++;
    final_report;
  end
endmodule
